// *** rtl/wrsu_pkg.sv ***
package wrsu_pkg;

    // register addresses on the special-function bus
    localparam logic [7:0] WRSU_WAKE_CONFIG_ADDR     = 8'hB5;
    localparam logic [7:0] WRSU_WAKE_FLAG_EXTRA_ADDR = 8'hCE;
    localparam logic [7:0] WRSU_RESET_CAUSE_ADDR     = 8'hEF;

    // wake_config field positions
    localparam int WRSU_CFG_SLEEP   = 7;
    localparam int WRSU_CFG_SUSPEND = 6;
    localparam int WRSU_CFG_CLEAR   = 5;
    localparam int WRSU_CFG_PINWK   = 4;

    // wake source index inside the flag and enable vectors
    localparam int WRSU_WK_FAIL  = 3;
    localparam int WRSU_WK_ALARM = 2;
    localparam int WRSU_WK_PMAT  = 1;
    localparam int WRSU_WK_COMP  = 0;

    // reset_cause field positions
    localparam int WRSU_RC_RTC    = 7;
    localparam int WRSU_RC_FLASH  = 6;
    localparam int WRSU_RC_COMP   = 5;
    localparam int WRSU_RC_SOFT   = 4;
    localparam int WRSU_RC_WDOG   = 3;
    localparam int WRSU_RC_MCD    = 2;
    localparam int WRSU_RC_SUPPLY = 1;
    localparam int WRSU_RC_PIN    = 0;

    // synchronised input index
    localparam int WRSU_IN_ALARM = 0;
    localparam int WRSU_IN_FAIL  = 1;
    localparam int WRSU_IN_PMAT  = 2;
    localparam int WRSU_IN_COMP  = 3;
    localparam int WRSU_IN_CAP   = 4;
    localparam int WRSU_IN_PIN   = 5;
    localparam int WRSU_IN_W     = 6;

    // reset values
    localparam logic [3:0] WRSU_WAKE_EN_RST = 4'h0;
    localparam logic [7:0] WRSU_CAUSE_POR   = 8'h02;
    localparam logic [7:0] WRSU_BYTE_ZERO   = 8'h00;

    // timing
    localparam int         WRSU_CLK_PERIOD_PS = 4000;
    localparam int         WRSU_PIN_HOLD_US   = 15;
    localparam int         WRSU_PIN_HOLD_CYC  =
        (WRSU_PIN_HOLD_US * 1000000 + WRSU_CLK_PERIOD_PS - 1) / WRSU_CLK_PERIOD_PS + 1;
    localparam logic [11:0] WRSU_PIN_HOLD_CNT = 12'(WRSU_PIN_HOLD_CYC);
    localparam logic [1:0]  WRSU_MASK_CYC     = 2'h2;

    // power state
    typedef enum logic [1:0] {
        WRSU_RUN,
        WRSU_SUSPEND,
        WRSU_SLEEP
    } wrsu_pstate_t;

    // rising edge of a sampled level
    function automatic logic wrsu_rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

endpackage

// *** rtl/wrsu_sync2.sv ***
`timescale 1ns/1ns
module wrsu_sync2 import wrsu_pkg::*; #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             nrst_i,
    input  wire logic             ce_i,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_reg;   // first stage, read only by second

    // two-stage synchroniser
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else if (ce_i) begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end

endmodule

// *** rtl/wrsu_core.sv ***
`timescale 1ns/1ns
// Behaviour
// - write sleep bit enters sleep mode
// - write suspend bit enters suspend mode
// - clear bit clears all wake flags
// - pin falling edge sets pin flag
// - clock-fail wake enable and flag
// - alarm wake enable and flag
// - port match wake enable and flag
// - comparator rise wake enable and flag
// - any flag set blocks low power
// - flags read zero two cycles after suspend
// - extra register: cap-sense enable and flag
// - rtc reset enable and cause flag
// - flash error reset cause flag
// - comparator reset enable and cause flag
// - soft reset force and cause flag
// - watchdog reset cause flag
// - missing clock enable and cause flag
// - supply reset enable, power-on flag
// - pin reset cause flag
// - reset cause register not safe for rmw: reads return flags, writes set enables and force soft reset
// - pin wakes sleep, stay awake 15 us
module wrsu_core import wrsu_pkg::*; (
    // clock, reset, enable
    input  wire logic       core_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    // special-function register port
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    // asynchronous wake sources
    input  wire logic       rtc_alarm_i,
    input  wire logic       rtc_osc_fail_i,
    input  wire logic       port_match_i,
    input  wire logic       comparator_i,
    input  wire logic       cap_sense_i,
    input  wire logic       rst_pin_n_i,
    // same-domain reset sources
    input  wire logic       watchdog_ovf_i,
    input  wire logic       flash_err_i,
    input  wire logic       clock_missing_i,
    input  wire logic       supply_fail_i,
    // power and reset control
    output logic            sleep_o,
    output logic            suspend_o,
    output logic            lp_osc_keep_o,
    output logic            sys_reset_o,
    output logic            missing_clock_enable_o,
    output logic            supply_reset_enable_o
);

    logic [WRSU_IN_W-1:0] sync_q;          // synchronised sources
    logic [WRSU_IN_W-1:0] prev_reg;        // previous synchronised value
    wrsu_pstate_t         pstate_reg;      // power state
    logic [3:0]           wake_en_reg;     // wake source enables
    logic [4:0]           wake_flag_reg;   // pin flag and four source flags
    logic                 cap_en_reg;      // cap-sense wake enable
    logic                 cap_flag_reg;    // cap-sense wake flag
    logic [1:0]           mask_cnt_reg;    // flag read mask after suspend
    logic [11:0]          hold_cnt_reg;    // stay awake after pin wake
    logic [11:0]          pin_low_cnt_reg; // pin held low length
    logic                 rtc_rst_en_reg;  // rtc as reset source
    logic                 comp_rst_en_reg; // comparator as reset source
    logic [7:0]           cause_reg;       // last reset cause

    logic       wr_cfg, wr_extra, wr_cause;  // write decodes
    logic       rd_cfg, rd_extra, rd_cause;  // read decodes
    logic [4:0] set_flag;                    // flag set events
    logic       set_cap;                     // cap flag set event
    logic       flag_any;                    // any wake flag up
    logic       enter_ok;                    // low power may be entered
    logic       mask_on;                     // flags hidden
    logic [7:0] cause_next;                  // cause of a new reset
    logic       pin_fall;                    // falling edge on reset pin

    wrsu_sync2 #(.WIDTH(WRSU_IN_W)) u_sync (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .ce_i       (ce_i),
        .d_i        ({rst_pin_n_i, cap_sense_i, comparator_i,
                      port_match_i, rtc_osc_fail_i, rtc_alarm_i}),
        .q_o        (sync_q)
    );

    // address decode
    always_comb begin
        wr_cfg   = 1'b0;
        wr_extra = 1'b0;
        wr_cause = 1'b0;
        rd_cfg   = 1'b0;
        rd_extra = 1'b0;
        rd_cause = 1'b0;
        if (sfr_addr_i == WRSU_WAKE_CONFIG_ADDR) begin
            wr_cfg = sfr_wr_i;
            rd_cfg = sfr_rd_i;
        end else if (sfr_addr_i == WRSU_WAKE_FLAG_EXTRA_ADDR) begin
            wr_extra = sfr_wr_i;
            rd_extra = sfr_rd_i;
        end else if (sfr_addr_i == WRSU_RESET_CAUSE_ADDR) begin
            wr_cause = sfr_wr_i;
            rd_cause = sfr_rd_i;
        end
    end

    // wake events, each gated by its enable except the pin falling edge
    always_comb begin
        pin_fall = wrsu_rise(prev_reg[WRSU_IN_PIN], sync_q[WRSU_IN_PIN]);
        set_flag[WRSU_CFG_PINWK] = pin_fall;
        set_flag[WRSU_WK_FAIL]  = wake_en_reg[WRSU_WK_FAIL]
            & wrsu_rise(sync_q[WRSU_IN_FAIL], prev_reg[WRSU_IN_FAIL]);
        set_flag[WRSU_WK_ALARM] = wake_en_reg[WRSU_WK_ALARM]
            & wrsu_rise(sync_q[WRSU_IN_ALARM], prev_reg[WRSU_IN_ALARM]);
        set_flag[WRSU_WK_PMAT]  = wake_en_reg[WRSU_WK_PMAT]
            & wrsu_rise(sync_q[WRSU_IN_PMAT], prev_reg[WRSU_IN_PMAT]);
        set_flag[WRSU_WK_COMP]  = wake_en_reg[WRSU_WK_COMP]
            & wrsu_rise(sync_q[WRSU_IN_COMP], prev_reg[WRSU_IN_COMP]);
        // cap-sense unit stops in sleep, so it only wakes suspend
        set_cap = cap_en_reg & (pstate_reg != WRSU_SLEEP)
            & wrsu_rise(sync_q[WRSU_IN_CAP], prev_reg[WRSU_IN_CAP]);
    end

    // entry guard
    always_comb begin
        flag_any = (|wake_flag_reg) | cap_flag_reg;
        // flags, fresh events and the pin hold window all block entry
        enter_ok = !flag_any && !(|set_flag) && !set_cap
            && (hold_cnt_reg == 12'h000);
        mask_on  = (mask_cnt_reg != 2'h0);
    end

    // new reset cause, highest priority first
    always_comb begin
        cause_next = WRSU_BYTE_ZERO;
        if (supply_fail_i && supply_reset_enable_o) begin
            cause_next[WRSU_RC_SUPPLY] = 1'b1;
        end else if (!sync_q[WRSU_IN_PIN] && (pin_low_cnt_reg == WRSU_PIN_HOLD_CNT)) begin
            cause_next[WRSU_RC_PIN] = 1'b1;
        end else if (clock_missing_i && missing_clock_enable_o) begin
            cause_next[WRSU_RC_MCD] = 1'b1;
        end else if (watchdog_ovf_i) begin
            cause_next[WRSU_RC_WDOG] = 1'b1;
        end else if (flash_err_i) begin
            cause_next[WRSU_RC_FLASH] = 1'b1;
        end else if (comp_rst_en_reg
                     && wrsu_rise(sync_q[WRSU_IN_COMP], prev_reg[WRSU_IN_COMP])) begin
            cause_next[WRSU_RC_COMP] = 1'b1;
        end else if (rtc_rst_en_reg
                     && (wrsu_rise(sync_q[WRSU_IN_ALARM], prev_reg[WRSU_IN_ALARM])
                     || wrsu_rise(sync_q[WRSU_IN_FAIL], prev_reg[WRSU_IN_FAIL]))) begin
            cause_next[WRSU_RC_RTC] = 1'b1;
        end else if (wr_cause && sfr_wdata_i[WRSU_RC_SOFT]) begin
            cause_next[WRSU_RC_SOFT] = 1'b1;
        end
    end

    // edge history
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            prev_reg <= '0;
        end else if (ce_i) begin
            prev_reg <= sync_q;
        end
    end

    // wake enables, rewritten on every config write; cap enable on every extra write
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            wake_en_reg <= WRSU_WAKE_EN_RST;
            cap_en_reg  <= 1'b0;
        end else if (ce_i) begin
            if (wr_cfg) begin
                wake_en_reg <= sfr_wdata_i[3:0];
            end
            if (wr_extra) begin
                cap_en_reg <= sfr_wdata_i[0];
            end
        end
    end

    // wake flags: sticky, set wins over clear
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            wake_flag_reg <= 5'h00;
            cap_flag_reg  <= 1'b0;
        end else if (ce_i) begin
            if (wr_cfg && sfr_wdata_i[WRSU_CFG_CLEAR]) begin
                wake_flag_reg <= set_flag;
                cap_flag_reg  <= set_cap;
            end else begin
                wake_flag_reg <= wake_flag_reg | set_flag;
                cap_flag_reg  <= cap_flag_reg | set_cap;
            end
        end
    end

    // power state machine
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            pstate_reg   <= WRSU_RUN;
            sleep_o      <= 1'b0;
            suspend_o    <= 1'b0;
            mask_cnt_reg <= 2'h0;
        end else if (ce_i) begin
            if (mask_on) begin
                mask_cnt_reg <= mask_cnt_reg - 2'h1;
            end
            case (pstate_reg)
                WRSU_RUN: begin
                    if (wr_cfg && sfr_wdata_i[WRSU_CFG_SLEEP] && enter_ok) begin
                        pstate_reg <= WRSU_SLEEP;
                        sleep_o    <= 1'b1;
                    end else if (wr_cfg && sfr_wdata_i[WRSU_CFG_SUSPEND] && enter_ok) begin
                        pstate_reg <= WRSU_SUSPEND;
                        suspend_o  <= 1'b1;
                    end
                end
                WRSU_SUSPEND: begin
                    if ((|set_flag) || set_cap || (|cause_next)) begin
                        pstate_reg   <= WRSU_RUN;
                        suspend_o    <= 1'b0;
                        mask_cnt_reg <= WRSU_MASK_CYC;
                    end
                end
                WRSU_SLEEP: begin
                    if ((|set_flag) || (|cause_next)) begin
                        pstate_reg <= WRSU_RUN;
                        sleep_o    <= 1'b0;
                    end
                end
                default: begin
                    pstate_reg <= WRSU_RUN;
                    sleep_o    <= 1'b0;
                    suspend_o  <= 1'b0;
                end
            endcase
        end
    end

    // pin wake hold window and pin low length
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            hold_cnt_reg    <= 12'h000;
            pin_low_cnt_reg <= 12'h000;
        end else if (ce_i) begin
            if (pin_fall) begin
                hold_cnt_reg <= WRSU_PIN_HOLD_CNT;
            end else if (hold_cnt_reg != 12'h000) begin
                hold_cnt_reg <= hold_cnt_reg - 12'h001;
            end
            if (sync_q[WRSU_IN_PIN]) begin
                pin_low_cnt_reg <= 12'h000;
            end else if (pin_low_cnt_reg != WRSU_PIN_HOLD_CNT) begin
                pin_low_cnt_reg <= pin_low_cnt_reg + 12'h001;
            end
        end
    end

    // reset enables and reset cause
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            rtc_rst_en_reg         <= 1'b0;
            comp_rst_en_reg        <= 1'b0;
            missing_clock_enable_o <= 1'b0;
            supply_reset_enable_o  <= 1'b0;
            cause_reg              <= WRSU_CAUSE_POR;
            sys_reset_o            <= 1'b0;
        end else if (ce_i) begin
            sys_reset_o <= |cause_next;
            if (|cause_next) begin
                cause_reg <= cause_next;
            end
            // enable bits only; flag bits ignore writes
            if (wr_cause) begin
                rtc_rst_en_reg         <= sfr_wdata_i[WRSU_RC_RTC];
                comp_rst_en_reg        <= sfr_wdata_i[WRSU_RC_COMP];
                missing_clock_enable_o <= sfr_wdata_i[WRSU_RC_MCD];
                supply_reset_enable_o  <= sfr_wdata_i[WRSU_RC_SUPPLY];
            end
        end
    end

    // registered read data and oscillator keep-alive
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            sfr_rdata_o   <= WRSU_BYTE_ZERO;
            lp_osc_keep_o <= 1'b0;
        end else if (ce_i) begin
            lp_osc_keep_o <= flag_any;
            if (rd_cfg) begin
                // mode and clear bits read zero
                sfr_rdata_o <= {3'h0, mask_on ? 5'h00 : wake_flag_reg};
            end else if (rd_extra) begin
                sfr_rdata_o <= {7'h00, cap_flag_reg & !mask_on};
            end else if (rd_cause) begin
                sfr_rdata_o <= cause_reg;
            end else if (sfr_rd_i) begin
                sfr_rdata_o <= WRSU_BYTE_ZERO;
            end
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i || !ce_i);

    sequence s_sleep_req;
        (pstate_reg == WRSU_RUN) && wr_cfg && sfr_wdata_i[WRSU_CFG_SLEEP] && enter_ok;
    endsequence

    sequence s_left_suspend;
        $fell(suspend_o);
    endsequence

    property p_sleep_enter;
        s_sleep_req |=> sleep_o && !suspend_o;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

    property p_suspend_enter;
        (pstate_reg == WRSU_RUN) && wr_cfg && enter_ok
            && sfr_wdata_i[WRSU_CFG_SUSPEND] && !sfr_wdata_i[WRSU_CFG_SLEEP] |=> suspend_o;
    endproperty
    a_suspend_enter: assert property (p_suspend_enter) else $error("no suspend");

    property p_clear_all;
        wr_cfg && sfr_wdata_i[WRSU_CFG_CLEAR] && !(|set_flag) && !set_cap
            |=> (wake_flag_reg == 5'h00) && !cap_flag_reg;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("flags not cleared");

    property p_pin_flag;
        pin_fall |=> wake_flag_reg[WRSU_CFG_PINWK] && (hold_cnt_reg == WRSU_PIN_HOLD_CNT);
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("pin flag missing");

    property p_refuse;
        flag_any && (pstate_reg == WRSU_RUN) |=> $stable(pstate_reg) ##0 !sleep_o && !suspend_o;
    endproperty
    a_refuse: assert property (p_refuse) else $error("low power with flag set");

    property p_suspend_mask;
        s_left_suspend |-> mask_on [*2] ##1 !mask_on;
    endproperty
    a_suspend_mask: assert property (p_suspend_mask) else $error("read mask wrong");

    // upper bits stay zero and bit 0 carries the cap flag once the mask is gone
    property p_extra_high_zero;
        rd_extra && !mask_on |=> sfr_rdata_o == {7'h00, $past(cap_flag_reg)};
    endproperty
    a_extra_high_zero: assert property (p_extra_high_zero) else $error("extra bits set");

    // with no competing cause the soft write alone must be recorded
    property p_soft_reset;
        wr_cause && sfr_wdata_i[WRSU_RC_SOFT] && !supply_fail_i && !watchdog_ovf_i
            && !flash_err_i && !clock_missing_i && sync_q[WRSU_IN_PIN]
            && !comp_rst_en_reg && !rtc_rst_en_reg
            |=> sys_reset_o ##0 (cause_reg[WRSU_RC_SOFT] && $onehot(cause_reg));
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset lost");

    property p_wake_from_sleep;
        (pstate_reg == WRSU_SLEEP) && (|set_flag) |=> !sleep_o ##1 !sleep_o;
    endproperty
    a_wake_from_sleep: assert property (p_wake_from_sleep) else $error("no wake");

    property p_pin_hold;
        (hold_cnt_reg != 12'h000) && wr_cfg && sfr_wdata_i[WRSU_CFG_SLEEP] |=> !sleep_o;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("slept inside pin hold");

endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
module tb_top import wrsu_pkg::*; ();
    // clock, reset, enable
    logic       core_clk_i = 1'b0;
    logic       nrst_i     = 1'b0;
    logic       ce_i       = 1'b1;
    // register port
    logic [7:0] sfr_addr_i  = 8'h00;
    logic       sfr_wr_i    = 1'b0;
    logic       sfr_rd_i    = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic [7:0] sfr_rdata_o;
    // wake sources: comparator, port match, alarm, clock fail
    logic [3:0] src  = 4'h0;
    logic       cap  = 1'b0;
    logic       pin_n = 1'b1;
    // same-clock causes: watchdog, flash, missing clock, supply
    logic [3:0] same = 4'h0;
    // power and reset outputs
    logic       sleep_o, suspend_o, lp_osc_keep_o, sys_reset_o;
    logic       missing_clock_enable_o, supply_reset_enable_o;
    int         num_errors  = 0;
    int         comparisons = 0;

    // free-running 250 MHz clock
    always #2 core_clk_i = ~core_clk_i;

    wrsu_core dut (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .rtc_alarm_i(src[2]), .rtc_osc_fail_i(src[3]), .port_match_i(src[1]),
        .comparator_i(src[0]), .cap_sense_i(cap), .rst_pin_n_i(pin_n),
        .watchdog_ovf_i(same[0]), .flash_err_i(same[1]), .clock_missing_i(same[2]),
        .supply_fail_i(same[3]), .sleep_o(sleep_o), .suspend_o(suspend_o),
        .lp_osc_keep_o(lp_osc_keep_o), .sys_reset_o(sys_reset_o),
        .missing_clock_enable_o(missing_clock_enable_o),
        .supply_reset_enable_o(supply_reset_enable_o)
    );

    // compare one byte, count and report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        sfr_addr_i  = a;
        sfr_wdata_i = d;
        sfr_wr_i    = 1'b1;
        @(negedge core_clk_i);
        sfr_wr_i    = 1'b0;
    endtask

    // one-cycle read strobe, data judged one cycle later
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input bit now);
        if (!now) begin
            @(negedge core_clk_i);
        end
        sfr_addr_i = a;
        sfr_rd_i   = 1'b1;
        @(negedge core_clk_i);
        sfr_rd_i   = 1'b0;
        chk(sfr_rdata_o, exp);
    endtask

    // bounded wait for sleep (0), suspend (1) or system reset (2)
    task automatic wait_sig(input int k, input logic lvl, input int lim);
        int n;
        n = 0;
        while ((k == 0 ? sleep_o : k == 1 ? suspend_o : sys_reset_o) !== lvl) begin
            @(negedge core_clk_i);
            n++;
            if (n > lim) begin
                chk(8'hEE, 8'h00);
                return;
            end
        end
    endtask

    // power-on values and unmapped read
    task automatic t_reset_values();
        rd(WRSU_RESET_CAUSE_ADDR, 8'h02, 0);
        rd(WRSU_WAKE_CONFIG_ADDR, 8'h00, 0);
        rd(WRSU_WAKE_FLAG_EXTRA_ADDR, 8'h00, 0);
        rd(8'h5A, 8'h00, 0);
    endtask

    // each wake source ends sleep, latches its flag, blocks re-entry
    task automatic t_sleep_sources();
        logic [7:0] b;
        for (int k = 0; k < 4; k++) begin
            b = 8'h01 << k;
            // the sleep write carries its wake enable in the same byte
            wr(WRSU_WAKE_CONFIG_ADDR, 8'h80 | b);
            chk({7'h00, sleep_o}, 8'h01);
            src[k] = 1'b1;
            wait_sig(0, 1'b0, 10);
            src = 4'h0;
            rd(WRSU_WAKE_CONFIG_ADDR, b, 0);
            chk({7'h00, lp_osc_keep_o}, 8'h01);
            wr(WRSU_WAKE_CONFIG_ADDR, 8'hC0 | b);
            chk({6'h00, sleep_o, suspend_o}, 8'h00);
            wr(WRSU_WAKE_CONFIG_ADDR, 8'h20);
            rd(WRSU_WAKE_CONFIG_ADDR, 8'h00, 0);
        end
    endtask

    // disabled source ignored, flags masked right after suspend ends
    task automatic t_suspend();
        wr(WRSU_WAKE_CONFIG_ADDR, 8'h44);
        chk({7'h00, suspend_o}, 8'h01);
        src[3] = 1'b1;
        repeat (6) @(negedge core_clk_i);
        chk({7'h00, suspend_o}, 8'h01);
        src[2] = 1'b1;
        wait_sig(1, 1'b0, 10);
        rd(WRSU_WAKE_CONFIG_ADDR, 8'h00, 1);
        rd(WRSU_WAKE_CONFIG_ADDR, 8'h04, 0);
        src = 4'h0;
        wr(WRSU_WAKE_CONFIG_ADDR, 8'h20);
    endtask

    // cap-sense flag, its clearing and its enable
    task automatic t_cap();
        wr(WRSU_WAKE_FLAG_EXTRA_ADDR, 8'h01);
        cap = 1'b1;
        repeat (4) @(negedge core_clk_i);
        cap = 1'b0;
        rd(WRSU_WAKE_FLAG_EXTRA_ADDR, 8'h01, 0);
        wr(WRSU_WAKE_CONFIG_ADDR, 8'h40);
        chk({7'h00, suspend_o}, 8'h00);
        wr(WRSU_WAKE_CONFIG_ADDR, 8'h20);
        rd(WRSU_WAKE_FLAG_EXTRA_ADDR, 8'h00, 0);
        wr(WRSU_WAKE_FLAG_EXTRA_ADDR, 8'hFE);
        cap = 1'b1;
        repeat (4) @(negedge core_clk_i);
        cap = 1'b0;
        rd(WRSU_WAKE_FLAG_EXTRA_ADDR, 8'h00, 0);
    endtask

    // every reset cause but the pin: enable, trigger, one pulse, recorded cause
    task automatic t_reset_cause();
        logic [7:0] en_t  [7] = '{8'h00, 8'h00, 8'h04, 8'h02, 8'h20, 8'h80, 8'h10};
        logic [3:0] same_t[7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h0, 4'h0};
        logic [3:0] src_t [7] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h4, 4'h0};
        logic [7:0] exp_t [7] = '{8'h08, 8'h40, 8'h04, 8'h02, 8'h20, 8'h80, 8'h10};
        for (int i = 0; i < 7; i++) begin
            // supply monitor has long settled here, so its enable is safe to set
            wr(WRSU_RESET_CAUSE_ADDR, en_t[i]);
            chk({missing_clock_enable_o, supply_reset_enable_o},
                {6'h00, en_t[i][2:1]});
            if ((same_t[i] | src_t[i]) != 4'h0) begin
                @(negedge core_clk_i);
                same = same_t[i];
                src  = src_t[i];
                @(negedge core_clk_i);
                same = 4'h0;
            end
            wait_sig(2, 1'b1, 10);
            @(negedge core_clk_i);
            chk({7'h00, sys_reset_o}, 8'h00);
            src = 4'h0;
            rd(WRSU_RESET_CAUSE_ADDR, exp_t[i], 0);
            wr(WRSU_RESET_CAUSE_ADDR, 8'h00);
        end
    endtask

    // reset pin wakes sleep, sets its flag, then resets the system
    task automatic t_pin();
        wr(WRSU_WAKE_CONFIG_ADDR, 8'h80);
        chk({7'h00, sleep_o}, 8'h01);
        pin_n = 1'b0;
        wait_sig(0, 1'b0, 10);
        rd(WRSU_WAKE_CONFIG_ADDR, 8'h10, 0);
        // stay awake, no sleep write, until the pin reset lands
        wait_sig(2, 1'b1, 3800);
        pin_n = 1'b1;
        rd(WRSU_RESET_CAUSE_ADDR, 8'h01, 0);
    endtask

    // main sequence
    initial begin
        repeat (12) @(negedge core_clk_i);
        nrst_i = 1'b1;
        t_reset_values();
        t_sleep_sources();
        t_suspend();
        t_cap();
        t_reset_cause();
        t_pin();
        conclude();
    end

    // hang guard, well above the expected run length
    initial begin
        repeat (20000) @(posedge core_clk_i);
        num_errors++;
        conclude();
    end
endmodule
